// *** hdl/smm_master.sv ***
// phase-1 spi master: user word port on mclk, serial engine on the link clock
// assumes control words change only while the link is idle
`timescale 1ns/1ps
module smm_master
	import smm_pkg::*;
#(
	parameter int WORD_W = WORD_W_DEF
) (
	// system clock and reset
	input  wire logic              mclk,
	input  wire logic              arst_n,
	// link clock
	input  wire logic              lowSpeedPeriphClock,
	// control words
	input  wire logic [REG_W-1:0]  operationControlReg,
	input  wire logic [REG_W-1:0]  charConfigReg,
	input  wire logic [BAUD_W-1:0] baudDivisor,
	// transmit words
	input  wire logic              txValid,
	input  wire logic [WORD_W-1:0] txData,
	output logic                   txReady,
	// received words
	output logic                   rxValid,
	output logic [WORD_W-1:0]      rxData,
	// serial pins
	output logic                   serialClockOut,
	output logic                   masterOutData,
	output logic                   slaveSelectN,
	input  wire logic              masterInData
);

	initial begin
		if (WORD_W < 2 || WORD_W > WORD_W_MAX) $error("smm_master: WORD_W out of range");
	end

	// ---------------- mclk side ----------------
	logic              txReady_q;
	logic              rxValid_q;
	logic [WORD_W-1:0] txData_q;
	logic [WORD_W-1:0] rxData_q;
	logic              reqTog_q;
	logic              ackSeen_q;
	logic              rxSeen_q;
	logic              ackS;
	logic              rxTogS;
	smm_cfg_t          cfgM;

	// link-side registers read across the crossing
	logic              ackTog_q;
	logic              rxTog_q;
	logic [WORD_W-1:0] rxHold_q;

	assign cfgM.master   = operationControlReg[OPCTL_MASTER_BIT];
	assign cfgM.phase    = operationControlReg[OPCTL_PHASE_BIT];
	assign cfgM.polarity = charConfigReg[CCR_POL_BIT];
	assign cfgM.baud     = baudDivisor;

	smm_sync #(.W(2)) uSyncToM (
		.clk    (mclk),
		.arst_n (arst_n),
		.d      ({ackTog_q, rxTog_q}),
		.q      ({ackS, rxTogS})
	);

	// a word stays in txData_q until the link acknowledges it, so it crosses stable
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			txReady_q <= 1'b1;
			txData_q  <= '0;
			reqTog_q  <= 1'b0;
			ackSeen_q <= 1'b0;
		end else if (txValid && txReady_q) begin
			txData_q  <= txData;
			reqTog_q  <= ~reqTog_q;
			txReady_q <= 1'b0;
		end else if (ackS != ackSeen_q) begin
			ackSeen_q <= ackS;
			txReady_q <= 1'b1;
		end
	end

	// rxHold_q is stable for a whole word after its toggle, far longer than the sync delay
	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rxSeen_q  <= 1'b0;
			rxValid_q <= 1'b0;
			rxData_q  <= '0;
		end else begin
			rxValid_q <= (rxTogS != rxSeen_q);
			if (rxTogS != rxSeen_q) begin
				rxSeen_q <= rxTogS;
				rxData_q <= rxHold_q;
			end
		end
	end

	assign txReady = txReady_q;
	assign rxValid = rxValid_q;
	assign rxData  = rxData_q;

	// ---------------- link side ----------------
	smm_cfg_t          cfgS;
	logic              misoS;
	logic              reqS;
	smm_state_t        state_q;
	logic [CNT_W-1:0]  cnt_q;
	logic [4:0]        bitCnt_q;
	logic [WORD_W-1:0] txSh_q;
	logic [WORD_W-1:0] rxSh_q;
	logic              sclk_q;
	logic              mosi_q;
	logic              ssN_q;
	logic              pending;
	logic              enabled;
	logic              lastBit;
	logic [CNT_W-1:0]  firstHalf;
	logic [CNT_W-1:0]  secondHalf;

	smm_sync #(.W($bits(smm_cfg_t) + 2)) uSyncToL (
		.clk    (lowSpeedPeriphClock),
		.arst_n (arst_n),
		.d      ({cfgM, reqTog_q, masterInData}),
		.q      ({cfgS, reqS, misoS})
	);

	assign pending    = (reqS != ackTog_q);
	assign enabled    = cfgS.master && cfgS.phase;
	assign lastBit    = (bitCnt_q == 5'(WORD_W - 1));
	assign firstHalf  = smm_first_half(cfgS.baud);
	assign secondHalf = smm_second_half(cfgS.baud);

	always_ff @(posedge lowSpeedPeriphClock or negedge arst_n) begin
		if (!arst_n) begin
			state_q  <= ST_IDLE;
			cnt_q    <= CNT_ZERO;
			bitCnt_q <= '0;
			txSh_q   <= '0;
			rxSh_q   <= '0;
			rxHold_q <= '0;
			rxTog_q  <= 1'b0;
			ackTog_q <= 1'b0;
			sclk_q   <= 1'b0;
			mosi_q   <= 1'b0;
			ssN_q    <= 1'b1;
		end else begin
			case (state_q)
				ST_IDLE: begin
					sclk_q <= cfgS.polarity;
					cnt_q  <= CNT_ZERO;
					if (pending && enabled) begin
						txSh_q   <= txData_q;
						mosi_q   <= txData_q[WORD_W-1];
						cnt_q    <= CNT_ZERO - SYNC_PAD;
						ssN_q    <= 1'b0;
						ackTog_q <= ~ackTog_q;
						bitCnt_q <= '0;
						state_q  <= ST_LEAD;
					end
				end
				// waits the second half before each leading edge; a frame's first bit waits SYNC_PAD more
				ST_LEAD: begin
					if (cnt_q == secondHalf - CNT_ONE) begin
						cnt_q   <= CNT_ZERO;
						sclk_q  <= ~cfgS.polarity;
						rxSh_q  <= {rxSh_q[WORD_W-2:0], misoS};
						state_q <= ST_TRAIL;
					end else begin
						cnt_q <= cnt_q + CNT_ONE;
					end
				end
				ST_TRAIL: begin
					if (cnt_q == firstHalf - CNT_ONE) begin
						cnt_q  <= CNT_ZERO;
						sclk_q <= cfgS.polarity;
						if (lastBit) begin
							rxHold_q <= rxSh_q;
							rxTog_q  <= ~rxTog_q;
							if (pending && enabled) begin
								// next word follows with no gap in select
								txSh_q   <= txData_q;
								mosi_q   <= txData_q[WORD_W-1];
								ackTog_q <= ~ackTog_q;
								bitCnt_q <= '0;
								state_q  <= ST_LEAD;
							end else begin
								ssN_q   <= 1'b1;
								state_q <= ST_IDLE;
							end
						end else begin
							txSh_q   <= txSh_q << 1;
							mosi_q   <= txSh_q[WORD_W-2];
							bitCnt_q <= bitCnt_q + 5'h01;
							state_q  <= ST_LEAD;
						end
					end else begin
						cnt_q <= cnt_q + CNT_ONE;
					end
				end
				default: begin
					state_q <= ST_IDLE;
					ssN_q   <= 1'b1;
				end
			endcase
		end
	end

	assign serialClockOut = sclk_q;
	assign masterOutData  = mosi_q;
	assign slaveSelectN   = ssN_q;

	// ---------------- checks ----------------
	logic             prevSclk_q;
	logic [CNT_W-1:0] age_q;
	logic [CNT_W-1:0] heldAge_q;
	logic             sclkMoved;
	logic             leadEdge;
	logic             trailEdge;

	assign sclkMoved = (sclk_q != prevSclk_q);
	assign leadEdge  = sclkMoved && (sclk_q != cfgS.polarity);
	assign trailEdge = sclkMoved && (sclk_q == cfgS.polarity);

	// age_q counts how long the current level has stood, saturating when idle
	always_ff @(posedge lowSpeedPeriphClock or negedge arst_n) begin
		if (!arst_n) begin
			prevSclk_q <= 1'b0;
			age_q      <= CNT_ZERO;
			heldAge_q  <= CNT_ZERO;
		end else begin
			prevSclk_q <= sclk_q;
			if (sclkMoved) begin
				age_q     <= CNT_ONE;
				heldAge_q <= age_q;
			end else if (age_q != 8'hff) begin
				age_q <= age_q + CNT_ONE;
			end
		end
	end

	default clocking cbL @(posedge lowSpeedPeriphClock); endclocking
	default disable iff (!arst_n);

	a_period_total: assert property (leadEdge && bitCnt_q != 5'h00 && !ssN_q |->
		({1'b0, age_q} + {1'b0, heldAge_q}) == {1'b0, smm_period(cfgS.baud)})
		else $error("serial clock period wrong");
	a_first_half: assert property (trailEdge && !$past(ssN_q) |->
		age_q == (smm_period(cfgS.baud) >> 1))
		else $error("first half length wrong");
	a_second_half: assert property (leadEdge && bitCnt_q != 5'h00 |->
		age_q == smm_period(cfgS.baud) - (smm_period(cfgS.baud) >> 1))
		else $error("second half length wrong");
	a_data_around_edge: assert property (leadEdge |->
		$stable(mosi_q) && mosi_q == $past(mosi_q, 2) ##1 $stable(mosi_q))
		else $error("data not held around leading edge");
	a_select_lead: assert property (leadEdge |-> !ssN_q && !$past(ssN_q) && !$past(ssN_q, 2))
		else $error("select not low before edge");
	a_select_release: assert property ($rose(ssN_q) |-> trailEdge && $past(bitCnt_q) == 5'(WORD_W - 1))
		else $error("select released at wrong moment");
	a_word_chain: assert property (trailEdge && $past(lastBit) && $past(pending && enabled) |-> !ssN_q ##1 !ssN_q)
		else $error("select dropped between words");
	a_mode_gate: assert property ($fell(ssN_q) |-> $past(cfgS.master) && $past(cfgS.phase))
		else $error("word started outside master phase-1");
	a_idle_level: assert property (ssN_q && $past(ssN_q) && $past(state_q) == ST_IDLE |->
		sclk_q == $past(cfgS.polarity))
		else $error("idle clock level wrong");
	a_sample_edge: assert property (leadEdge |-> rxSh_q[0] == $past(misoS))
		else $error("input not sampled on receiving edge");

	c_word_done: cover property ($rose(ssN_q));
	c_back_to_back: cover property (trailEdge && $past(lastBit) && !ssN_q ##1 !ssN_q);
	c_odd_period: cover property (leadEdge && cfgS.baud[0] == 1'b0 && cfgS.baud > BAUD_SHORT_MAX);
	c_polarity_high: cover property ($fell(ssN_q) && cfgS.polarity);

endmodule : smm_master

// *** hdl/smm_pkg.sv ***
// constants, types and helpers for the phase-1 spi master
// assumes the control words arrive as quasi-static levels from the mclk side
// Behaviour
// - period four cycles, else divisor plus one
// - even periods 4..128 with equal halves
// - odd periods: first half shorter by half
// - data valid half cycle around first edge
// - select low half cycle plus SYNC_PAD before first edge
// - select released half cycle after last sample
// - select held low between back-to-back words
// - master bit 2, phase bit 3 enable
// - polarity bit 6 picks the active edge
package smm_pkg;

	localparam int REG_W           = 8;
	localparam int BAUD_W          = 7;
	localparam int CNT_W           = 8;
	localparam int OPCTL_MASTER_BIT = 2;
	localparam int OPCTL_PHASE_BIT  = 3;
	localparam int CCR_POL_BIT      = 6;
	localparam int WORD_W_DEF       = 8;
	localparam int WORD_W_MAX       = 16;

	// divisor values up to this one give the fixed short period
	localparam logic [BAUD_W-1:0] BAUD_SHORT_MAX = 7'h02;
	localparam logic [CNT_W-1:0]  PERIOD_SHORT   = 8'h04;
	localparam logic [CNT_W-1:0]  CNT_ONE        = 8'h01;
	localparam logic [CNT_W-1:0]  CNT_ZERO       = 8'h00;
	// extra lead-in so the first returned bit has cleared the input synchroniser
	localparam logic [CNT_W-1:0]  SYNC_PAD       = 8'h02;

	typedef struct packed {
		logic              master;
		logic              phase;
		logic              polarity;
		logic [BAUD_W-1:0] baud;
	} smm_cfg_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_LEAD,
		ST_TRAIL
	} smm_state_t;

	// serial clock period in link clock cycles
	function automatic logic [CNT_W-1:0] smm_period(input logic [BAUD_W-1:0] baud);
		smm_period = (baud <= BAUD_SHORT_MAX) ? PERIOD_SHORT : ({1'b0, baud} + CNT_ONE);
	endfunction : smm_period

	// first half rounds down, so an odd period shortens it by half a cycle
	function automatic logic [CNT_W-1:0] smm_first_half(input logic [BAUD_W-1:0] baud);
		smm_first_half = smm_period(baud) >> 1;
	endfunction : smm_first_half

	function automatic logic [CNT_W-1:0] smm_second_half(input logic [BAUD_W-1:0] baud);
		smm_second_half = smm_period(baud) - smm_first_half(baud);
	endfunction : smm_second_half

endpackage : smm_pkg

// *** hdl/smm_sync.sv ***
// two-stage level synchroniser, any width
// assumes multi-bit inputs are stable or change one bit at a time
`timescale 1ns/1ps
module smm_sync #(
	parameter int W = 1
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         arst_n,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : smm_sync

// *** tb/smm_slave.sv ***
// behavioural spi slave: a shift register looped back to the master
// assumes phase-1 framing; each bit is held only as long as the master is owed
`timescale 1ns/1ps
module smm_slave #(
	parameter int W = 8
) (
	// link side
	input  wire logic       linkClk,
	input  wire logic       pol,
	input  wire logic [7:0] period,
	// serial pins
	input  wire logic       sclk,
	input  wire logic       ssN,
	input  wire logic       mosi,
	output logic            miso
);
	logic [W-1:0] shReg    = '0;
	logic         heldBit  = 1'b0;
	logic         junkQ    = 1'b0;
	logic         sclkPrev = 1'b0;
	int           holdCnt  = 0;
	// a released line toggles, so a stale bit never passes for data
	assign miso = ssN ? junkQ : ((holdCnt != 0) ? heldBit : shReg[W-1]);
	always @(negedge linkClk) begin
		sclkPrev <= sclk;
		junkQ    <= ~junkQ;
		if (!ssN && sclkPrev == pol && sclk != pol) begin
			shReg   <= {shReg[W-2:0], mosi};
			heldBit <= shReg[W-1];
			holdCnt <= period[0] ? int'(period >> 1) : int'(period >> 2);
		end else if (holdCnt != 0)
			holdCnt <= holdCnt - 1;
	end
endmodule : smm_slave

// *** tb/tb_smm_master.sv ***
// self-checking bench for the phase-1 spi master and a looped-back slave
// assumes the slave echoes each word one word later, so rx is checked one behind
`timescale 1ns/1ps
module tb_smm_master;
	import smm_pkg::*;
	logic              mclk, lsClk, arst_n, txValid, txReady, rxValid;
	logic              sclk, mosi, ssN, miso, pPrev, ssPrev, fromSel;
	logic [REG_W-1:0]  opCtl, ccr;
	logic [BAUD_W-1:0] baud;
	logic [7:0]        txData, rxData, lastTx, period, halfExp;
	logic [7:0]        expQ[$];
	int                fail_count, comparisons, seed, cnt, selFalls, selRises, n0;
	// periods of 4 to 7 link cycles keep the rate far inside the limits
	logic [6:0]        bauds[6] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06};
	logic [7:0]        offCodes[2] = '{8'h08, 8'h04};

	assign period = (baud <= 7'h02) ? 8'h04 : ({1'b0, baud} + 8'h01);
	assign halfExp = (sclk == ccr[CCR_POL_BIT]) ? (period >> 1) : (period - (period >> 1));

	smm_master #(.WORD_W(8)) smm_master_inst (.mclk(mclk), .arst_n(arst_n), .lowSpeedPeriphClock(lsClk),
		.operationControlReg(opCtl), .charConfigReg(ccr), .baudDivisor(baud), .txValid(txValid),
		.txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .serialClockOut(sclk),
		.masterOutData(mosi), .slaveSelectN(ssN), .masterInData(miso));
	smm_slave smm_slave_inst (.linkClk(lsClk), .pol(ccr[CCR_POL_BIT]), .period(period), .sclk(sclk),
		.ssN(ssN), .mosi(mosi), .miso(miso));

	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	initial begin
		lsClk = 1'b0;
		#7.3;
		forever #16 lsClk = ~lsClk;
	end

	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : report_and_stop

	// called just after a rising mclk edge; txValid stays up for chained words
	task automatic sendWord(input logic [7:0] w);
		txValid <= 1'b1;
		txData  <= w;
		do @(posedge mclk); while (txReady !== 1'b1);
		expQ.push_back(lastTx);
		lastTx = w;
	endtask : sendWord

	task automatic waitIdle;
		while (expQ.size() != 0) @(posedge mclk);
		repeat (4) @(posedge lsClk);
		@(posedge mclk);
	endtask : waitIdle

	always @(negedge mclk) if (rxValid === 1'b1) begin
		if (expQ.size() == 0) check("rx extra", 8'h01, 8'h00);
		else check("rx word", rxData, expQ.pop_front());
	end

	// half-period lengths in link cycles, counted from select fall or the last edge
	always @(negedge lsClk) begin
		pPrev  <= sclk;
		ssPrev <= ssN;
		if (ssPrev && !ssN) begin
			cnt     <= 1;
			fromSel <= 1'b1;
			selFalls++;
		end else if (!ssPrev && sclk != pPrev) begin
			check("half period", cnt[7:0], halfExp + (fromSel ? SYNC_PAD : 8'h00));
			cnt     <= 1;
			fromSel <= 1'b0;
		end else
			cnt <= cnt + 1;
		if (!ssPrev && ssN) begin
			selRises++;
			check("release on edge", {7'h00, sclk != pPrev}, 8'h01);
		end
	end

	initial begin
		#300000;
		fail_count++;
		$display("[ERR] watchdog expected done seen hang");
		report_and_stop;
	end

	initial begin
		seed = 99482;
		{fail_count, comparisons, cnt, selFalls, selRises} = '0;
		{pPrev, ssPrev, txValid, fromSel} = 4'h4;
		// reset by nba so every flop process already waits for the edge
		arst_n <= 1'b0;
		{txData, lastTx, ccr} = '0;
		opCtl = 8'h0c;
		baud  = 7'h00;
		repeat (2) @(posedge lsClk);
		@(posedge mclk);
		arst_n <= 1'b1;
		repeat (4) @(posedge lsClk);
		foreach (bauds[i]) for (int p = 0; p < 2; p++) begin
			@(posedge mclk);
			ccr  <= 8'(p << CCR_POL_BIT);
			baud <= bauds[i];
			repeat (4) @(posedge lsClk);
			@(posedge mclk);
			check("idle clock", {7'h00, sclk}, 8'(p));
			n0 = selRises;
			for (int k = 0; k < 3; k++) sendWord(8'($random(seed)));
			txValid <= 1'b0;
			waitIdle;
			check("select rises", 8'(selRises - n0), 8'h01);
		end
		// words must wait while master or phase is off
		foreach (offCodes[i]) begin
			opCtl <= offCodes[i];
			repeat (4) @(posedge lsClk);
			@(posedge mclk);
			n0 = selFalls;
			sendWord(8'($random(seed)));
			txValid <= 1'b0;
			repeat (40) @(posedge lsClk);
			check("held off", 8'(selFalls - n0), 8'h00);
			@(posedge mclk);
			opCtl <= 8'h0c;
			waitIdle;
		end
		sendWord(8'h00);
		txValid <= 1'b0;
		waitIdle;
		report_and_stop;
	end
endmodule : tb_smm_master
